// ===== src/data_move_pkg.sv
package data_move_pkg;
    // four internal phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam int PHASES_PER_CYCLE = 4;
    localparam int COPY_CYCLES = 2;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;

    // opcode fields
    localparam logic [3:0] COPY_FIRST_NIB = 4'hC;
    localparam logic [3:0] COPY_SECOND_NIB = 4'hF;
    localparam logic [11:0] BANK_LOAD_HI = 12'h010;
    localparam logic [7:0] LIT_LOAD_HI = 8'h0E;
    localparam logic [6:0] STORE_HI = 7'h37;
    localparam int ACCESS_BIT = 8;

    // reset values
    localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_COPY_SRC,
        OP_COPY_DST,
        OP_BANK_LOAD,
        OP_LIT_LOAD,
        OP_STORE
    } move_op_e;

    typedef enum logic {
        ST_FETCH,
        ST_COPY_DEST
    } exec_state_e;
endpackage

// ===== src/q_phase_counter.sv
`timescale 1ns/1ps
module q_phase_counter (
    input wire logic clock,
    input wire logic rst,
    output logic [1:0] phase
);
    import data_move_pkg::*;

    logic [1:0] next_phase;

    // wraps Q4 back to Q1 by width
    always_comb begin
        next_phase = phase + 2'h1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end
endmodule // q_phase_counter

// ===== src/data_move_instruction_exec.sv
`timescale 1ns/1ps
// How it works
// - copy is two words, first 1100 plus source, second 1111 plus dest.
// - copy writes source byte into destination, no status flag changes.
// - copy addresses reach all of 000h..FFFh, bank select unused.
// - accumulator's data-space address works as copy source or dest.
// - copy takes two words and two instruction cycles.
// - bank load 0000_0001_0000_kkkk puts k in bank select, one cycle.
// - literal load 0000_1110 plus byte puts byte in accumulator.
// - access bit zero picks access bank, one picks bank select value.
module data_move_instruction_exec #(
    parameter logic [data_move_pkg::ADDR_W-1:0] ACCUM_ADDR = 12'hF00,
    parameter logic [data_move_pkg::BANK_W-1:0] ACCESS_BANK = 4'h0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [data_move_pkg::WORD_W-1:0] instrWord,
    input wire logic [data_move_pkg::DATA_W-1:0] dataRdData,
    output logic [1:0] phase,
    output logic [data_move_pkg::ADDR_W-1:0] dataAddr,
    output logic dataRd,
    output logic dataWr,
    output logic [data_move_pkg::DATA_W-1:0] dataWrData,
    output logic [data_move_pkg::DATA_W-1:0] accum,
    output logic [data_move_pkg::BANK_W-1:0] bankSel,
    output logic copyPending,
    output logic instrDone
);
    import data_move_pkg::*;

    exec_state_e state, next_state;
    move_op_e curOp, next_curOp;
    logic [ADDR_W-1:0] operand, next_operand;
    logic [DATA_W-1:0] srcData, next_srcData;
    logic [ADDR_W-1:0] next_dataAddr;
    logic next_dataRd, next_dataWr, next_instrDone;
    logic [DATA_W-1:0] next_dataWrData, next_accum;
    logic [BANK_W-1:0] next_bankSel;
    logic [ADDR_W-1:0] storeAddr;
    // tells fetch that the next word is a destination, not an opcode
    logic next_copyPending;
    move_op_e decodedOp;

    q_phase_counter u_phase (
        .clock(clock),
        .rst(rst),
        .phase(phase)
    );

    always_comb begin
        decodedOp = OP_NONE;
        if (state == ST_COPY_DEST) begin
            // second word taken as dest whatever its top nibble
            decodedOp = OP_COPY_DST;
        end else if (instrWord[15:12] == COPY_FIRST_NIB) begin
            decodedOp = OP_COPY_SRC;
        end else if (instrWord[15:4] == BANK_LOAD_HI) begin
            decodedOp = OP_BANK_LOAD;
        end else if (instrWord[15:8] == LIT_LOAD_HI) begin
            decodedOp = OP_LIT_LOAD;
        end else if (instrWord[15:9] == STORE_HI) begin
            decodedOp = OP_STORE;
        end
    end

    // access bit zero overrides bank select
    assign storeAddr = operand[ACCESS_BIT] ? {bankSel, operand[7:0]}
        : {ACCESS_BANK, operand[7:0]};

    always_comb begin
        next_state = state;
        next_curOp = curOp;
        next_operand = operand;
        next_srcData = srcData;
        next_dataAddr = dataAddr;
        next_dataRd = dataRd;
        next_dataWr = dataWr;
        next_dataWrData = dataWrData;
        next_accum = accum;
        next_bankSel = bankSel;
        next_instrDone = 1'b0;
        case (phase)
            PH_Q1: begin
                next_curOp = decodedOp;
                next_operand = instrWord[11:0];
                if (decodedOp == OP_COPY_SRC) begin
                    // full 12-bit address, no bank applied
                    next_dataAddr = instrWord[11:0];
                    // accumulator read internally, no bus cycle
                    next_dataRd = (instrWord[11:0] != ACCUM_ADDR);
                end
            end
            PH_Q2: begin
                next_dataRd = 1'b0;
                if (curOp == OP_COPY_SRC) begin
                    next_srcData = (operand == ACCUM_ADDR) ? accum
                        : dataRdData;
                end
            end
            PH_Q3: begin
                if (curOp == OP_COPY_DST && operand != ACCUM_ADDR) begin
                    next_dataAddr = operand;
                    next_dataWr = 1'b1;
                    next_dataWrData = srcData;
                end else if (curOp == OP_STORE) begin
                    next_dataAddr = storeAddr;
                    next_dataWr = 1'b1;
                    next_dataWrData = accum;
                end
            end
            PH_Q4: begin
                next_dataWr = 1'b0;
                next_instrDone = (curOp != OP_COPY_SRC);
                next_state = (curOp == OP_COPY_SRC) ? ST_COPY_DEST
                                                    : ST_FETCH;
                case (curOp)
                    OP_BANK_LOAD: next_bankSel = operand[3:0];
                    OP_LIT_LOAD: next_accum = operand[7:0];
                    OP_COPY_DST: begin
                        if (operand == ACCUM_ADDR) begin
                            next_accum = srcData;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
            end
        endcase
        next_copyPending = (next_state == ST_COPY_DEST);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_FETCH;
            curOp <= OP_NONE;
            operand <= ADDR_RESET;
            srcData <= ACCUM_RESET;
            dataAddr <= ADDR_RESET;
            dataRd <= 1'b0;
            dataWr <= 1'b0;
            dataWrData <= ACCUM_RESET;
            accum <= ACCUM_RESET;
            bankSel <= BANK_RESET;
            copyPending <= 1'b0;
            instrDone <= 1'b0;
        end else begin
            state <= next_state;
            curOp <= next_curOp;
            operand <= next_operand;
            srcData <= next_srcData;
            dataAddr <= next_dataAddr;
            dataRd <= next_dataRd;
            dataWr <= next_dataWr;
            dataWrData <= next_dataWrData;
            accum <= next_accum;
            bankSel <= next_bankSel;
            copyPending <= next_copyPending;
            instrDone <= next_instrDone;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic copyStart;
    assign copyStart = phase == PH_Q1 && state == ST_FETCH
                       && instrWord[15:12] == COPY_FIRST_NIB;

    AST_COPY_SRC_READ: assert property (
        copyStart && instrWord[11:0] != ACCUM_ADDR
        |=> dataRd && dataAddr == $past(instrWord[11:0]))
        else $error("copy source read not issued");
    AST_COPY_TWO_CYCLES: assert property (
        copyStart |=> (!instrDone) [*7] ##1 instrDone)
        else $error("copy did not finish in two cycles");
    AST_COPY_DEST_WRITE: assert property (
        phase == PH_Q1 && state == ST_COPY_DEST
        && instrWord[11:0] != ACCUM_ADDR
        |-> ##3 dataWr && phase == PH_Q4 && dataWrData == srcData
            && dataAddr == $past(instrWord[11:0], 3))
        else $error("copy destination write wrong");
    AST_NO_READ_SECOND: assert property (
        state == ST_COPY_DEST |-> !dataRd)
        else $error("read during copy second cycle");
    AST_ACC_DEST: assert property (
        phase == PH_Q4 && curOp == OP_COPY_DST && operand == ACCUM_ADDR
        |-> !dataWr ##1 accum == $past(srcData))
        else $error("copy into accumulator wrong");
    AST_BANK_LOAD: assert property (
        phase == PH_Q1 && state == ST_FETCH
        && instrWord[15:4] == BANK_LOAD_HI
        |-> ##4 bankSel == $past(instrWord[3:0], 4) && instrDone)
        else $error("bank select load wrong");
    AST_LIT_LOAD: assert property (
        phase == PH_Q1 && state == ST_FETCH
        && instrWord[15:8] == LIT_LOAD_HI
        |-> ##4 accum == $past(instrWord[7:0], 4) && !dataWr)
        else $error("literal load wrong");
    AST_STORE: assert property (
        phase == PH_Q3 && curOp == OP_STORE
        |=> dataWr && dataWrData == accum && dataAddr == (operand[8]
            ? {bankSel, operand[7:0]} : {ACCESS_BANK, operand[7:0]}))
        else $error("store write wrong");
    AST_WRITE_ONLY_Q4: assert property (
        dataWr |-> phase == PH_Q4)
        else $error("write outside fourth phase");
    // a stalled phase counter would stretch every instruction
    AST_PHASE_STEP: assert property (
        !$past(rst) |-> phase == 2'($past(phase) + 2'h1))
        else $error("phase did not advance by one");
    AST_COPY_PENDING: assert property (
        copyStart |-> !copyPending ##4 copyPending [*4] ##1 !copyPending)
        else $error("copy second cycle flag wrong");

    COV_COPY: cover property (copyStart ##8 instrDone);
    COV_COPY_ACC: cover property (curOp == OP_COPY_DST
                                  && operand == ACCUM_ADDR);
    COV_BANK: cover property (curOp == OP_BANK_LOAD && phase == PH_Q4);
    COV_STORE: cover property (curOp == OP_STORE && dataWr);
endmodule // data_move_instruction_exec

// ===== verif/data_space_model.sv
`timescale 1ns/1ps
module data_space_model (
    input wire logic clock,
    input wire logic [11:0] dataAddr,
    input wire logic dataRd,
    input wire logic dataWr,
    input wire logic [7:0] dataWrData,
    output logic [7:0] dataRdData
);
    logic [7:0] mem [0:4095];
    // bus not read shows inverted data, so a wrong-phase sample fails
    assign dataRdData = dataRd ? mem[dataAddr] : ~mem[dataAddr];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    always @(posedge clock) begin
        if (dataWr === 1'b1) begin
            mem[dataAddr] <= dataWrData;
        end
    end
endmodule // data_space_model

// ===== verif/data_move_instruction_exec_tb.sv
`timescale 1ns/1ps
module data_move_instruction_exec_tb;
    import data_move_pkg::*;
    localparam logic [11:0] ACC = 12'hF00;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instrWord = 16'h0000;
    logic [7:0] dataRdData, dataWrData, accum, k, v, expAcc;
    logic [1:0] phase;
    logic [11:0] dataAddr, s, d;
    logic dataRd, dataWr, copyPending, instrDone;
    logic [3:0] bankSel, b;
    int errTotal = 0;
    int comparisons = 0;
    int reads = 0;
    always #5 clock = ~clock;
    data_move_instruction_exec #(.ACCUM_ADDR(ACC), .ACCESS_BANK(4'h0)) i_dut (
        .clock(clock), .rst(rst), .instrWord(instrWord),
        .dataRdData(dataRdData), .phase(phase), .dataAddr(dataAddr),
        .dataRd(dataRd), .dataWr(dataWr), .dataWrData(dataWrData),
        .accum(accum), .bankSel(bankSel), .copyPending(copyPending),
        .instrDone(instrDone));
    data_space_model i_mem (
        .clock(clock), .dataAddr(dataAddr), .dataRd(dataRd),
        .dataWr(dataWr), .dataWrData(dataWrData), .dataRdData(dataRdData));
    always @(posedge clock) begin
        if (dataRd === 1'b1) reads <= reads + 1;
    end
    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // word set just before a Q1 edge, then nop so it is not re-executed
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge clock);
        while (phase !== PH_Q4 && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (n >= 8) begin
            errTotal++;
            closeOut();
        end
        @(posedge clock);
        instrWord <= w;
        @(posedge clock);
        instrWord <= 16'h0000;
    endtask
    task automatic finish_instr(input string what);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (instrDone !== 1'b1 && n < 20);
        check({what, " latency"}, 12'h004, 12'(n));
        if (instrDone !== 1'b1) closeOut();
    endtask
    task automatic copy(input logic [11:0] src, input logic [11:0] dst);
        int r0;
        logic [11:0] expReads;
        // read counter has one driver, so take a snapshot instead
        r0 = reads;
        expReads = (src == ACC) ? 12'h000 : 12'h001;
        issue({COPY_FIRST_NIB, src});
        issue({COPY_SECOND_NIB, dst});
        finish_instr("copy");
        check("copy reads", expReads, 12'(reads - r0));
    endtask
    initial begin
        void'($urandom(32'hea59));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check("reset accum", 12'(ACCUM_RESET), 12'(accum));
        check("reset bank", 12'(BANK_RESET), 12'(bankSel));
        for (int i = 0; i < 6; i++) begin
            k = (i < 2) ? {8{i[0]}} : 8'($urandom);
            issue({LIT_LOAD_HI, k});
            expAcc = k;
            finish_instr("literal");
            check("accum", 12'(k), 12'(accum));
        end
        $display("test literal done");
        for (int i = 0; i < 16; i++) begin
            issue({BANK_LOAD_HI, 4'(i)});
            finish_instr("bank");
            check("bankSel", 12'(i), 12'(bankSel));
        end
        $display("test bank done");
        for (int i = 0; i < 8; i++) begin
            k = 8'($urandom);
            // bank 15 kept out, its byte 0 is the accumulator
            b = 4'($urandom_range(14));
            v = 8'($urandom);
            issue({LIT_LOAD_HI, k});
            expAcc = k;
            finish_instr("literal");
            issue({BANK_LOAD_HI, b});
            finish_instr("bank");
            issue({STORE_HI, i[0], v});
            finish_instr("store");
            s = {i[0] ? b : 4'h0, v};
            check("store", 12'(k), 12'(i_mem.mem[s]));
        end
        $display("test store done");
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            d = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
            // no counter or stack bytes mapped, no interrupts enabled
            if (d == ACC) d = d ^ 12'h001;
            if (i == 6) s = ACC;
            if (i == 7) d = ACC;
            v = (s == ACC) ? expAcc : i_mem.mem[s];
            copy(s, d);
            if (d == ACC) expAcc = v;
            k = (d == ACC) ? accum : i_mem.mem[d];
            check("copy", 12'(v), 12'(k));
        end
        $display("test copy done");
        closeOut();
    end
endmodule // data_move_instruction_exec_tb
